/* move_fill_pkg.sv */
// Purpose: shared constants and types for the move, masked move and fill datapath
// Assumes: 16-bit data words, word addresses into one flat data memory
// Notes: register map is reached over Avalon-MM, one 32-bit word per register
package move_fill_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_SOURCE = 6'h04;
  localparam logic [5:0] OFS_MASK = 6'h08;
  localparam logic [5:0] OFS_DEST = 6'h0c;
  localparam logic [5:0] OFS_LENGTH = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_TRAP = 6'h18;
  localparam logic [5:0] OFS_MATH = 6'h1c;
  // control field positions
  localparam int CTL_START = 0;
  localparam int CTL_RUNG = 1;
  localparam int CTL_SRC_CONST = 2;
  localparam int CTL_MASK_CONST = 3;
  localparam int CTL_DEST_CONST = 4;
  localparam int CTL_OP_LSB = 8;
  localparam int CTL_FTYPE_LSB = 12;
  // status word 0 flag positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_OVERFLOW = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGN = 3;
  // trap register field positions
  localparam int TRAP_BIT = 0;
  localparam int TRAP_SET_MATH = 1;
  localparam int TRAP_END = 2;
  localparam int TRAP_MAJOR = 3;
  localparam logic [15:0] MAJOR_ERR_CODE = 16'h0020;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // operations
  typedef enum logic [3:0] {
    OP_PLAIN_WORD_MOVE = 4'h0,
    OP_MASKED_WORD_MOVE = 4'h1,
    OP_FILE_FILL = 4'h2
  } op_t;
  // destination file types for the fill length limit
  typedef enum logic [3:0] {
    FT_OUT_DISC = 4'h0, FT_OUT_ANA = 4'h1, FT_IN_DISC = 4'h2, FT_IN_ANA = 4'h3,
    FT_STATUS = 4'h4, FT_BIT = 4'h5, FT_TIMER = 4'h6, FT_COUNTER = 4'h7,
    FT_CONTROL = 4'h8, FT_INTEGER = 4'h9
  } ftype_t;
  localparam logic [7:0] LIM_OUT_DISC = 8'h01;
  localparam logic [7:0] LIM_OUT_ANA = 8'h05;
  localparam logic [7:0] LIM_IN_DISC = 8'h02;
  localparam logic [7:0] LIM_IN_ANA = 8'h08;
  localparam logic [7:0] LIM_STATUS = 8'h21;
  localparam logic [7:0] LIM_BIT = 8'h20;
  localparam logic [7:0] LIM_TIMER = 8'h28;
  localparam logic [7:0] LIM_COUNTER = 8'h20;
  localparam logic [7:0] LIM_CONTROL = 8'h10;
  localparam logic [7:0] LIM_INTEGER = 8'h69;
  // error codes in status register bits 7:4
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_TWO_CONST = 4'h1;
  localparam logic [3:0] ERR_DEST_CONST = 4'h2;
  localparam logic [3:0] ERR_LENGTH = 4'h3;
  localparam logic [3:0] ERR_OPCODE = 4'h4;
endpackage : move_fill_pkg

/* move_fill_mask_datapath.sv */
// Purpose: execution datapath for plain move, masked move and file fill
// Assumes: data memory answers reads in the cycle after memRd
// Notes: software stages operands over Avalon-MM and pulses start per true scan
//   every memory read answers one cycle after its strobe, so each read spans two cycles
// What this block does
// - fill writes the one source value into every destination element over the length, each true scan, flags untouched.
// - fill writes elements in ascending address order starting at the first element.
// - fill length limit follows destination file type: output 1/5, input 2/8, status 33, bit 32, timer 40, counter 32, control 16, integer 105.
// - two-source instructions refuse two constants and every destination must be an address.
// - carry, overflow, zero and sign sit in bits 0 to 3 of status word 0 and refresh after each plain or masked move.
// - the overflow trap bit sets on a math overflow or divide by zero.
// - a trap bit still set at end or temporary end raises recoverable major error 0020.
// - move and logical operations leave the two-word math register unchanged.
// - plain move copies the source word or constant to the destination each true scan.
// - after plain move carry and overflow clear, zero follows result zero, sign follows bit 15.
// - masked move works on whole words through a mask word each true scan.
// - the mask is an addressed word or an immediate constant.
// - after masked move carry and overflow clear, zero and sign follow the result.
// - masked move takes source bits where the mask is one and keeps destination bits where it is zero.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module move_fill_mask_datapath
  import move_fill_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic [AW-1:0] memAddr,
  output logic memRd,
  output logic memWr,
  output logic [DW-1:0] memWrData,
  input wire logic [DW-1:0] memRdData,
  input wire logic mathOverflow,
  input wire logic divideByZero,
  input wire logic endOfScan,
  output logic busy,
  output logic majorError
);
  initial begin
    if (DW != 16) $error("data width must be 16");
    if (AW < 8 || AW > 16) $error("address width out of range");
  end

  typedef enum {S_IDLE, S_READ_SRC, S_READ_MASK, S_READ_DEST, S_WRITE, S_FILL} state_t;
  state_t state_reg;

  logic [15:0] ctrl_reg;
  logic [DW-1:0] source_reg, mask_reg, result_reg;
  logic [AW-1:0] dest_reg, fillPtr_reg;
  logic [7:0] length_reg, fillCnt_reg;
  logic [3:0] flags_reg, err_reg;
  logic trap_reg, major_reg;
  logic [DW-1:0] mathLow_reg, mathHigh_reg;
  logic [DW-1:0] srcVal_reg, maskVal_reg;
  logic [31:0] readData_reg;
  logic wait_reg;
  logic [1:0] step_reg; // phase of the mask and destination reads

  // fill length limit per destination file type
  function automatic logic [7:0] fill_limit(input logic [3:0] ft);
    case (ft)
      FT_OUT_DISC: fill_limit = LIM_OUT_DISC;
      FT_OUT_ANA: fill_limit = LIM_OUT_ANA;
      FT_IN_DISC: fill_limit = LIM_IN_DISC;
      FT_IN_ANA: fill_limit = LIM_IN_ANA;
      FT_STATUS: fill_limit = LIM_STATUS;
      FT_BIT: fill_limit = LIM_BIT;
      FT_TIMER: fill_limit = LIM_TIMER;
      FT_COUNTER: fill_limit = LIM_COUNTER;
      FT_CONTROL: fill_limit = LIM_CONTROL;
      FT_INTEGER: fill_limit = LIM_INTEGER;
      default: fill_limit = 8'h00;
    endcase
  endfunction : fill_limit

  // zero and sign from a result word, carry and overflow cleared
  function automatic logic [3:0] move_flags(input logic [DW-1:0] r);
    move_flags = '0;
    move_flags[FLAG_ZERO] = (r == '0);
    move_flags[FLAG_SIGN] = r[DW-1];
  endfunction : move_flags

  wire logic [3:0] opCode = ctrl_reg[CTL_OP_LSB +: 4];
  wire logic [3:0] fileType = ctrl_reg[CTL_FTYPE_LSB +: 4];
  wire logic srcConst = ctrl_reg[CTL_SRC_CONST];
  wire logic maskConst = ctrl_reg[CTL_MASK_CONST];
  wire logic destConst = ctrl_reg[CTL_DEST_CONST];
  wire logic wrCtrl = avsWrite && avsAddress == OFS_CONTROL && avsByteEnable[0];
  wire logic startReq = wrCtrl && avsWriteData[CTL_START] && avsWriteData[CTL_RUNG] && state_reg == S_IDLE;

  // operand check at start, from the incoming control word and the length register
  logic [3:0] startErr;
  always_comb begin
    startErr = ERR_NONE;
    if (avsWriteData[CTL_DEST_CONST]) startErr = ERR_DEST_CONST;
    else if (avsWriteData[CTL_OP_LSB +: 4] == OP_MASKED_WORD_MOVE &&
             avsWriteData[CTL_SRC_CONST] && avsWriteData[CTL_MASK_CONST]) startErr = ERR_TWO_CONST;
    else if (avsWriteData[CTL_OP_LSB +: 4] == OP_FILE_FILL &&
             (length_reg == 8'h00 || length_reg > fill_limit(avsWriteData[CTL_FTYPE_LSB +: 4])))
      startErr = ERR_LENGTH;
    else if (avsWriteData[CTL_OP_LSB +: 4] > OP_FILE_FILL) startErr = ERR_OPCODE;
  end

  // bus slave: one wait cycle on every access, then answer
  // waitrequest is high at rest and drops for exactly one cycle per request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(wait_reg && (avsRead || avsWrite));
    end
  end
  assign avsWaitRequest = wait_reg;

  // read data mux, unmapped offsets read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData_reg <= '0;
    end else if (avsRead && wait_reg) begin
      case (avsAddress)
        OFS_CONTROL: readData_reg <= {16'h0000, ctrl_reg};
        OFS_SOURCE: readData_reg <= {16'h0000, source_reg};
        OFS_MASK: readData_reg <= {16'h0000, mask_reg};
        OFS_DEST: readData_reg <= {{(32-AW){1'b0}}, dest_reg};
        OFS_LENGTH: readData_reg <= {24'h000000, length_reg};
        OFS_STATUS: readData_reg <= {23'h0, busy, err_reg, flags_reg};
        OFS_TRAP: readData_reg <= {MAJOR_ERR_CODE & {16{major_reg}}, 12'h000, major_reg, 2'b00, trap_reg};
        OFS_MATH: readData_reg <= {mathHigh_reg, mathLow_reg};
        default: readData_reg <= '0;
      endcase
    end
  end
  assign avsReadData = readData_reg;

  // operand registers written by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= RESET_WORD;
      source_reg <= RESET_WORD;
      mask_reg <= RESET_WORD;
      dest_reg <= '0;
      length_reg <= '0;
    end else if (avsWrite && !wait_reg) begin
      case (avsAddress)
        OFS_CONTROL: if (state_reg == S_IDLE) ctrl_reg <= {avsWriteData[15:1], 1'b0};
        OFS_SOURCE: source_reg <= avsWriteData[15:0];
        OFS_MASK: mask_reg <= avsWriteData[15:0];
        OFS_DEST: dest_reg <= avsWriteData[AW-1:0];
        OFS_LENGTH: length_reg <= avsWriteData[7:0];
        default: ;
      endcase
    end
  end

  // math register: only software writes it, this datapath never does
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mathLow_reg <= RESET_WORD;
      mathHigh_reg <= RESET_WORD;
    end else if (avsWrite && !wait_reg && avsAddress == OFS_MATH) begin
      mathLow_reg <= avsWriteData[15:0];
      mathHigh_reg <= avsWriteData[31:16];
    end
  end

  // sequencer
  wire logic startGo = startReq && !wait_reg && startErr == ERR_NONE;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      srcVal_reg <= '0;
      maskVal_reg <= '0;
      result_reg <= '0;
      fillPtr_reg <= '0;
      fillCnt_reg <= '0;
    end else begin
      case (state_reg)
        S_IDLE: if (startGo) begin
          state_reg <= avsWriteData[CTL_SRC_CONST] ? S_READ_MASK : S_READ_SRC;
          srcVal_reg <= source_reg;
          maskVal_reg <= mask_reg;
          fillPtr_reg <= dest_reg;
          fillCnt_reg <= length_reg;
        end
        // the source read issued at start is in flight for this one cycle
        S_READ_SRC: state_reg <= S_READ_MASK;
        // an addressed source word stands on the memory bus now, a constant was staged at start
        S_READ_MASK: begin
          if (!srcConst) srcVal_reg <= memRdData;
          if (opCode == OP_MASKED_WORD_MOVE) state_reg <= S_READ_DEST;
          else if (opCode == OP_FILE_FILL) state_reg <= S_FILL;
          else state_reg <= S_WRITE;
          if (opCode == OP_PLAIN_WORD_MOVE) result_reg <= srcConst ? srcVal_reg : memRdData;
        end
        // step 1 takes an addressed mask, step 3 takes the destination and merges
        S_READ_DEST: begin
          if (step_reg == 2'h1) maskVal_reg <= memRdData;
          if (step_reg == 2'h3) begin
            state_reg <= S_WRITE;
            result_reg <= (srcVal_reg & maskVal_reg) | (memRdData & ~maskVal_reg);
          end
        end
        S_WRITE: state_reg <= S_IDLE;
        S_FILL: begin
          fillPtr_reg <= fillPtr_reg + 1'b1;
          fillCnt_reg <= fillCnt_reg - 8'h01;
          if (fillCnt_reg == 8'h01) state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // read phase inside the destination read: even steps wait, odd steps take the answer
  // a constant mask starts at step 2 so only the destination is fetched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_reg <= 2'h0;
    end else if (state_reg == S_READ_MASK) begin
      step_reg <= maskConst ? 2'h2 : 2'h0;
    end else if (state_reg == S_READ_DEST) begin
      step_reg <= step_reg + 2'h1;
    end
  end

  // memory strobes and address, registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memRd <= 1'b0;
      memWr <= 1'b0;
      memAddr <= '0;
      memWrData <= '0;
    end else begin
      memRd <= 1'b0;
      memWr <= 1'b0;
      if (startGo && !avsWriteData[CTL_SRC_CONST]) begin
        memRd <= 1'b1;
        memAddr <= source_reg[AW-1:0];
      end else if (state_reg == S_READ_MASK && opCode == OP_MASKED_WORD_MOVE) begin
        memRd <= 1'b1; // the mask word, or the destination at once when the mask is a constant
        memAddr <= maskConst ? dest_reg : mask_reg[AW-1:0];
      end else if (state_reg == S_READ_DEST && step_reg == 2'h1) begin
        memRd <= 1'b1; // destination read once the addressed mask is in
        memAddr <= dest_reg;
      end else if (state_reg == S_WRITE) begin
        memWr <= 1'b1;
        memAddr <= dest_reg;
        memWrData <= result_reg;
      end else if (state_reg == S_FILL) begin
        memWr <= 1'b1;
        memAddr <= fillPtr_reg;
        memWrData <= srcVal_reg;
      end
    end
  end

  // arithmetic flags refreshed when a move finishes, operand error at each start request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= '0;
      err_reg <= ERR_NONE;
    end else begin
      if (startReq && !wait_reg) err_reg <= startErr;
      if (state_reg == S_WRITE) flags_reg <= move_flags(result_reg);
    end
  end

  // trap bit: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_reg <= 1'b0;
      major_reg <= 1'b0;
    end else begin
      if (mathOverflow || divideByZero) trap_reg <= 1'b1;
      else if (avsWrite && !wait_reg && avsAddress == OFS_TRAP && !avsWriteData[TRAP_BIT]) trap_reg <= 1'b0;
      if (endOfScan && trap_reg) major_reg <= 1'b1;
      else if (avsWrite && !wait_reg && avsAddress == OFS_TRAP && avsWriteData[TRAP_MAJOR]) major_reg <= 1'b0;
    end
  end

  // status outputs; busy falls as the last write is launched,
  // so that write lands one cycle after busy has dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      majorError <= 1'b0;
    end else begin
      busy <= startGo || (state_reg != S_IDLE && !(state_reg == S_WRITE) &&
              !(state_reg == S_FILL && fillCnt_reg == 8'h01));
      majorError <= major_reg || (endOfScan && trap_reg);
    end
  end
endmodule : move_fill_mask_datapath

/* move_fill_props.sv */
// Purpose: port checks for the move, masked move and fill datapath
// Assumes: one clock domain, async active-low reset
// Notes: bound to every datapath instance below
`timescale 1ns/1ps
module move_fill_props
  import move_fill_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitRequest,
  input wire logic [AW-1:0] memAddr,
  input wire logic memWr,
  input wire logic [DW-1:0] memWrData,
  input wire logic endOfScan,
  input wire logic busy,
  input wire logic majorError
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // bus answers in the next cycle and only for one cycle
  a_wait_prompt: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest) else $error("late answer");
  a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest) else $error("answer too long");
  // back-to-back writes belong to a fill: same word, next address
  a_fill_ascend: assert property (memWr && $past(memWr) |-> memAddr == $past(memAddr) + 1'b1) else $error("fill order");
  a_fill_value: assert property (memWr && $past(memWr) |-> $stable(memWrData)) else $error("fill word changed");
  // writes only while running or in the cycle after, runs end within 300 cycles, above the longest fill
  a_write_busy: assert property (memWr |-> busy || $past(busy)) else $error("write while idle");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:300] !busy) else $error("run too long");
  a_busy_cause: assert property ($rose(busy) |-> $past(avsWrite) || $past(avsWrite, 2)) else $error("run unasked");
  // fault only follows an end of scan
  a_major_end: assert property ($rose(majorError) |-> $past(endOfScan)) else $error("fault without end");
  // main scenarios
  c_fill: cover property (memWr && $past(memWr));
  c_major: cover property ($rose(majorError));
  c_run: cover property ($fell(busy));
endmodule : move_fill_props

bind move_fill_mask_datapath move_fill_props #(.DW(DW), .AW(AW)) u_props (
  .clk(clk), .reset_n(reset_n), .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest),
  .memAddr(memAddr), .memWr(memWr), .memWrData(memWrData), .endOfScan(endOfScan), .busy(busy),
  .majorError(majorError)
);

/* fill_mem_model.sv */
// Purpose: data memory seen by the datapath
// Assumes: read answer one cycle after the read pulse
// Notes: read data is not held outside the answer cycle
`timescale 1ns/1ps
module fill_mem_model
  import move_fill_pkg::*;
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [DATA_W-1:0] memWrData,
  output logic [DATA_W-1:0] memRdData
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  // write port and one-cycle read answer, inverted junk otherwise
  always @(posedge clk) begin
    if (memWr) begin
      mem[memAddr] <= memWrData;
    end
    memRdData <= memRd ? mem[memAddr] : ~memRdData;
  end
  initial begin
    memRdData = 16'h0000;
  end
endmodule : fill_mem_model

/* move_fill_mask_datapath_tb.sv */
// Purpose: self-checking bench for the move, masked move and fill datapath
// Assumes: bus answers per the hand-over timing, memory model behind it
// Notes: masked move and fill limit expectations come from operand tables below
`timescale 1ns/1ps
module move_fill_mask_datapath_tb;
  import move_fill_pkg::*;
  logic clk, reset_n, avsRead, avsWrite, avsWaitRequest, memRd, memWr, busy, majorError, me;
  logic mathOverflow, divideByZero, endOfScan;
  logic [5:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rd;
  logic [3:0] avsByteEnable;
  logic [11:0] memAddr;
  logic [15:0] memWrData, memRdData;
  int nMismatch = 0;
  int totalChecks = 0;
  logic [15:0] tSrc [3] = '{16'h5555, 16'h8000, 16'h0000};
  logic [15:0] tDst [3] = '{16'hffff, 16'h7fff, 16'h1234};
  logic [15:0] tMsk [3] = '{16'hf0f0, 16'h8000, 16'hffff};
  logic [7:0] tFlg [3] = '{8'h00, 8'h08, 8'h04};
  int tLim [10] = '{1, 5, 2, 8, 33, 32, 40, 32, 16, 105};

  move_fill_mask_datapath dut (
    .clk(clk), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWrData(memWrData),
    .memRdData(memRdData), .mathOverflow(mathOverflow), .divideByZero(divideByZero), .endOfScan(endOfScan),
    .busy(busy), .majorError(majorError)
  );
  fill_mem_model u_mem (
    .clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWrData(memWrData), .memRdData(memRdData)
  );

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one bus cycle, held until waitrequest is seen low at an edge
  task automatic avs(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
    end while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask : avs
  // start one instruction with a true rung and wait until idle
  task automatic go(input logic [3:0] op, input logic [3:0] ft, input logic [2:0] k);
    int n;
    avs(1'b1, OFS_CONTROL, {16'h0, ft, op, 3'h0, k, 2'h3}, rd);
    n = 0;
    repeat (2) @(posedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    repeat (2) @(posedge clk); // the last write lands one cycle after busy drops
  endtask : go
  task automatic stat(input string nm, input logic [7:0] exp);
    avs(1'b0, OFS_STATUS, 32'h0, rd);
    check(nm, {24'h0, rd[7:0]}, {24'h0, exp});
  endtask : stat
  // pulse {end, divide, overflow} then sample the fault level
  task automatic pulse(input logic [2:0] p);
    {endOfScan, divideByZero, mathOverflow} <= p;
    @(posedge clk);
    {endOfScan, divideByZero, mathOverflow} <= 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    me = majorError;
    @(posedge clk);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // watchdog
  initial begin
    #2000000;
    nMismatch++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {reset_n, avsRead, avsWrite, mathOverflow, divideByZero, endOfScan} = 6'h00;
    avsAddress = 6'h00;
    avsWriteData = 32'h0;
    avsByteEnable = 4'hf;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    avs(1'b1, OFS_MATH, 32'h1234abcd, rd);
    u_mem.mem[12'h010] = 16'h8001;
    u_mem.mem[12'h021] = 16'h7777;
    avs(1'b1, OFS_SOURCE, 32'h010, rd);
    avs(1'b1, OFS_DEST, 32'h020, rd);
    go(OP_PLAIN_WORD_MOVE, 4'h0, 3'h0);
    check("mov word", {16'h0, u_mem.mem[12'h020]}, 32'h8001);
    stat("mov flags", 8'h08);
    avs(1'b1, OFS_SOURCE, 32'h0, rd);
    avs(1'b1, OFS_DEST, 32'h021, rd);
    go(OP_PLAIN_WORD_MOVE, 4'h0, 3'h1);
    check("mov const", {16'h0, u_mem.mem[12'h021]}, 32'h0);
    stat("mov zero", 8'h04);
    // masked moves: constant and addressed masks
    for (int i = 0; i < 3; i++) begin
      u_mem.mem[12'h030 + i] = tSrc[i];
      u_mem.mem[12'h040 + i] = tDst[i];
      u_mem.mem[12'h050] = tMsk[i];
      avs(1'b1, OFS_SOURCE, 32'h030 + i, rd);
      avs(1'b1, OFS_MASK, (i != 1) ? {16'h0, tMsk[i]} : 32'h050, rd);
      avs(1'b1, OFS_DEST, 32'h040 + i, rd);
      go(OP_MASKED_WORD_MOVE, 4'h0, {1'b0, i != 1, 1'b0});
      check("mvm word", {16'h0, u_mem.mem[12'h040 + i]}, {16'h0, (tSrc[i] & tMsk[i]) | (tDst[i] & ~tMsk[i])});
      stat("mvm flags", tFlg[i]);
    end
    // fill keeps flags from the last masked move
    u_mem.mem[12'h105] = 16'h5a5a;
    avs(1'b1, OFS_SOURCE, 32'h00aa, rd);
    avs(1'b1, OFS_DEST, 32'h100, rd);
    avs(1'b1, OFS_LENGTH, 32'h5, rd);
    go(OP_FILE_FILL, FT_INTEGER, 3'h1);
    for (int j = 0; j < 6; j++) check("fill elem", {16'h0, u_mem.mem[12'h100 + j]}, j < 5 ? 32'h00aa : 32'h5a5a);
    stat("fill flags", 8'h04);
    // each file type: one past the limit refused, the limit itself runs
    avs(1'b1, OFS_DEST, 32'h200, rd);
    for (int i = 0; i < 10; i++) begin
      avs(1'b1, OFS_SOURCE, 32'h1100 + i, rd);
      u_mem.mem[12'h200 + tLim[i] - 1] = 16'hdead;
      u_mem.mem[12'h200 + tLim[i]] = 16'hbeef;
      avs(1'b1, OFS_LENGTH, tLim[i] + 1, rd);
      go(OP_FILE_FILL, 4'(i), 3'h1);
      stat("over limit", {ERR_LENGTH, 4'h4});
      check("over limit word", {16'h0, u_mem.mem[12'h200 + tLim[i] - 1]}, 32'hdead);
      avs(1'b1, OFS_LENGTH, tLim[i], rd);
      go(OP_FILE_FILL, 4'(i), 3'h1);
      check("limit last", {16'h0, u_mem.mem[12'h200 + tLim[i] - 1]}, 32'h1100 + i);
      check("limit past", {16'h0, u_mem.mem[12'h200 + tLim[i]]}, 32'hbeef);
    end
    // operand refusals
    go(OP_MASKED_WORD_MOVE, 4'h0, 3'h3);
    stat("two consts", {ERR_TWO_CONST, 4'h4});
    go(OP_PLAIN_WORD_MOVE, 4'h0, 3'h4);
    stat("dest const", {ERR_DEST_CONST, 4'h4});
    go(4'h3, 4'h0, 3'h0);
    stat("bad opcode", {ERR_OPCODE, 4'h4});
    avs(1'b1, OFS_CONTROL, 32'h0, rd);
    avs(1'b0, OFS_MATH, 32'h0, rd);
    check("math word", rd, 32'h1234abcd);
    avs(1'b0, 6'h20, 32'h0, rd);
    // trap bit, fault at end of scan, and both ways of clearing
    pulse(3'h1);
    avs(1'b0, OFS_TRAP, 32'h0, rd);
    check("trap set", {31'h0, rd[0]}, 32'h1);
    pulse(3'h4);
    check("fault", {31'h0, me}, 32'h1);
    avs(1'b0, OFS_TRAP, 32'h0, rd);
    check("fault code", {16'h0, rd[31:16]}, {16'h0, MAJOR_ERR_CODE});
    avs(1'b1, OFS_TRAP, 32'h8, rd);
    pulse(3'h2);
    check("fault cleared", {31'h0, me}, 32'h0);
    avs(1'b0, OFS_TRAP, 32'h0, rd);
    check("div trap", {31'h0, rd[0]}, 32'h1);
    avs(1'b1, OFS_TRAP, 32'h0, rd);
    pulse(3'h4);
    check("no fault", {31'h0, me}, 32'h0);
    tally_and_finish();
  end
endmodule : move_fill_mask_datapath_tb
